// ### hw/sc_channel.sv
// Purpose: Block transfer channel between private devices and memory.
// Assumes: One 40 MHz clock, synchronous high reset, synchronous inputs.
// Notes: Processor ops are one-cycle; each op to the channel or a private device gets one response later.
`timescale 1ns/1ps
`include "sc_defs.svh"

// ****************************************************************
// FIFO
// ****************************************************************
module sc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_clr,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem[rd_reg];

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || i_clr) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_reg <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_reg <= (AW+1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule : sc_fifo

// ****************************************************************
// Channel
// ****************************************************************
module sc_channel (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire sc_pkg::sc_op_t i_mpx_op,
  output sc_pkg::sc_rsp_t o_mpx_rsp,
  input wire logic i_tack_in,
  output logic o_tack_out,
  output logic o_irq,
  output sc_pkg::sc_op_t o_prv_op,
  input wire sc_pkg::sc_rsp_t i_prv_rsp,
  input wire logic [7:0] i_prv_status,
  input wire logic i_prv_attn,
  input wire logic i_prv_halfword,
  output logic [3:0] o_prv_sel,
  input wire sc_pkg::sc_word_t i_prv_din,
  output logic o_prv_din_ready,
  output sc_pkg::sc_word_t o_prv_dout,
  input wire logic i_prv_dout_ready,
  output sc_pkg::sc_mem_t o_mem,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] sc_put(input logic [31:0] cur, input logic [1:0] idx,
                                         input logic [7:0] b);
    sc_put = cur;
    sc_put[8*(3-idx) +: 8] = b;
  endfunction : sc_put

  function automatic logic sc_last(input logic [15:0] a, input logic [15:0] f);
    sc_last = (a[15:1] == f[15:1]);
  endfunction : sc_last

  // ****************************************************************
  // State
  // ****************************************************************
  sc_pkg::sc_state_t state_reg;
  logic read_reg;
  logic irq_reg;
  logic [31:0] lim_reg;
  logic [1:0] ld_idx_reg;
  logic rd_idx_reg;
  logic [15:0] mem_addr_reg;
  logic [15:0] last_addr_reg;
  logic [15:0] dev_addr_reg;
  logic fill_done_reg;
  logic [15:0] asm_reg;
  logic asm_half_reg;
  logic asm_full_reg;
  logic [7:0] prev_odd_reg;
  logic [15:0] out_word_reg;
  logic out_lo_reg;
  logic out_last_reg;
  sc_pkg::sc_rsp_t rsp_reg;
  sc_pkg::sc_op_t prv_op_reg;
  sc_pkg::sc_mem_t mem_reg;
  sc_pkg::sc_word_t dout_reg;
  logic din_ready_reg;
  logic tack_reg;
  logic [3:0] sel_reg;
  logic out_pending;
  logic out_step_last;
  logic end_now;
  logic mem_just_done;

  wire [15:0] final_addr = lim_reg[15:0];
  wire run = (state_reg == sc_pkg::SC_ST_RUN);
  wire idle = (state_reg == sc_pkg::SC_ST_IDLE);

  // ****************************************************************
  // Processor op decode
  // ****************************************************************
  wire to_chan = i_mpx_op.valid && (i_mpx_op.dev == `SC_DEV_NUM);
  wire to_prv = i_mpx_op.valid && (i_mpx_op.dev[7:4] == `SC_PRV_HI);
  wire op_cmd = to_chan && (i_mpx_op.kind == sc_pkg::SC_OP_CMD);
  wire op_ack = to_chan && (i_mpx_op.kind == sc_pkg::SC_OP_ACK);
  wire op_wb = to_chan && (i_mpx_op.kind == sc_pkg::SC_OP_WBYTE);
  wire op_wh = to_chan && (i_mpx_op.kind == sc_pkg::SC_OP_WHALF);
  wire op_rb = to_chan && (i_mpx_op.kind == sc_pkg::SC_OP_RBYTE);
  wire stop = op_cmd && i_mpx_op.data[`SC_CMD_STOP];
  wire go = op_cmd && i_mpx_op.data[`SC_CMD_GO] && !stop && idle;
  wire set_read = op_cmd && i_mpx_op.data[`SC_CMD_READ] && !stop;

  // Busy shows only the flag; idle shows the device with flag cleared
  wire [7:0] bsy_mask = 8'h01 << `SC_STAT_BSY;
  wire [7:0] stat_byte = run ? bsy_mask : (i_prv_status & ~bsy_mask);
  wire [7:0] idle_stat = i_prv_status & ~bsy_mask;
  wire [7:0] fault_mask = (8'h01 << `SC_STAT_EX) | (8'h01 << `SC_STAT_EOM) |
                          (8'h01 << `SC_STAT_DU);

  // ****************************************************************
  // FIFO and data path
  // ****************************************************************
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;

  // Read mode: device side fills, memory side drains; write mode swaps
  wire dev_last = sc_last(dev_addr_reg, final_addr);
  wire dev_one_byte = dev_last && !final_addr[0];
  wire dev_end = dev_last || (dev_addr_reg == `SC_ADDR_TOP);
  wire [15:0] asm_data = (dev_one_byte) ? {asm_reg[15:8], prev_odd_reg} : asm_reg;
  wire rd_push = run && read_reg && asm_full_reg && fifo_in_ready;
  wire wr_push = run && !read_reg && mem_reg.req && i_mem_ack;
  wire fifo_push = rd_push || wr_push;
  wire [15:0] fifo_in_data = read_reg ? asm_data : i_mem_rdata;
  wire mem_idle = !mem_reg.req;
  wire rd_pop = run && read_reg && fifo_out_valid && mem_idle;
  // Pop only into an empty output so the last-word test sees the settled address
  wire wr_pop = run && !read_reg && fifo_out_valid && !dout_reg.valid && !out_pending;
  wire fifo_pop = rd_pop || wr_pop;

  sc_fifo #(
    .WIDTH(`SC_FIFO_WIDTH),
    .DEPTH(`SC_FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_clr(idle),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );

  // ****************************************************************
  // Device side
  // ****************************************************************
  wire din_take = i_prv_din.valid && din_ready_reg;
  wire asm_done = din_take && (i_prv_halfword || asm_half_reg || dev_one_byte);
  wire asm_full_next = (asm_full_reg && !rd_push) || asm_done;
  wire dev_step = rd_push || out_step_last;
  wire fill_done_next = fill_done_reg || (rd_push && dev_last) ||
                        (wr_push && sc_last(mem_addr_reg, final_addr)) ||
                        (wr_push && (mem_addr_reg == `SC_ADDR_TOP));
  wire din_ready_next = run && read_reg && !end_now && !fill_done_next && !asm_full_next;
  // Write side: one halfword or two bytes per popped word, one byte for an even final address in byte mode
  wire dout_take = dout_reg.valid && i_prv_dout_ready;
  assign out_step_last = dout_take && !out_pending;
  wire wr_dev_done = out_step_last && out_last_reg;
  assign out_pending = out_lo_reg;

  // ****************************************************************
  // Memory side and termination
  // ****************************************************************
  wire mem_done = mem_reg.req && i_mem_ack;
  wire mem_last = sc_last(mem_addr_reg, final_addr);
  // Write mode ends instead once the device holds the word read at the top
  wire mem_wrap = read_reg && mem_done && !mem_last &&
                  (mem_addr_reg == `SC_ADDR_TOP);
  wire wr_issue = run && !read_reg && mem_idle && !fill_done_reg && fifo_in_ready &&
                  !mem_just_done;
  assign mem_just_done = mem_done;
  wire normal_end = read_reg ? (mem_done && mem_last) : wr_dev_done;
  wire fault_end = run && ((i_prv_status & fault_mask) != 8'h00);
  assign end_now = run && (stop || normal_end || mem_wrap || fault_end);

  // ****************************************************************
  // Response
  // ****************************************************************
  logic [15:0] rsp_data;
  always_comb begin
    rsp_data = 16'h0000;
    unique case (i_mpx_op.kind)
      sc_pkg::SC_OP_STAT: rsp_data = {8'h00, stat_byte};
      sc_pkg::SC_OP_ACK: rsp_data = {`SC_DEV_NUM, idle_stat};
      sc_pkg::SC_OP_RBYTE:
        rsp_data = {8'h00, rd_idx_reg ? last_addr_reg[7:0] : last_addr_reg[15:8]};
      sc_pkg::SC_OP_RHALF: rsp_data = last_addr_reg;
      default: rsp_data = 16'h0000;
    endcase
  end

  wire prv_pass = to_prv && idle;
  wire false_sync = to_prv && run;
  wire want_bus = irq_reg || (idle && i_prv_attn);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg <= sc_pkg::SC_ST_IDLE;
      read_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      if (end_now) begin
        state_reg <= sc_pkg::SC_ST_IDLE;
      end else if (go) begin
        state_reg <= sc_pkg::SC_ST_RUN;
      end
      read_reg <= (end_now || stop) ? 1'b0 : (set_read ? 1'b1 : read_reg);
      // New termination wins over an acknowledge in the same cycle
      irq_reg <= stop ? 1'b0 : ((end_now) ? 1'b1 : (op_ack ? 1'b0 : irq_reg));
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || stop) begin
      ld_idx_reg <= 2'b00;
      rd_idx_reg <= 1'b0;
    end else begin
      ld_idx_reg <= (idle && op_wb) ? 2'(ld_idx_reg + 1'b1) :
                    (idle && op_wh) ? 2'(ld_idx_reg + 2'd2) : ld_idx_reg;
      rd_idx_reg <= op_rb ? !rd_idx_reg : rd_idx_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      lim_reg <= `SC_LIM_RST;
    end else if (idle && op_wb) begin
      lim_reg <= sc_put(lim_reg, ld_idx_reg, i_mpx_op.data[7:0]);
    end else if (idle && op_wh) begin
      lim_reg <= sc_put(sc_put(lim_reg, ld_idx_reg, i_mpx_op.data[15:8]),
                        2'(ld_idx_reg + 1'b1), i_mpx_op.data[7:0]);
    end
  end

  // ****************************************************************
  // Address counters
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      mem_addr_reg <= `SC_ADDR_RST;
      last_addr_reg <= `SC_ADDR_RST;
      dev_addr_reg <= `SC_ADDR_RST;
      fill_done_reg <= 1'b0;
    end else if (go) begin
      mem_addr_reg <= lim_reg[31:16];
      last_addr_reg <= lim_reg[31:16];
      dev_addr_reg <= lim_reg[31:16];
      fill_done_reg <= 1'b0;
    end else if (run) begin
      if (mem_done) begin
        last_addr_reg <= mem_addr_reg;
        mem_addr_reg <= 16'(mem_addr_reg + 16'h0002);
      end
      if (dev_step && !dev_last) begin
        dev_addr_reg <= 16'(dev_addr_reg + 16'h0002);
      end
      fill_done_reg <= fill_done_next;
    end
  end

  // ****************************************************************
  // Memory requests, one outstanding; the arbiter grants by ack
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      mem_reg <= '0;
    end else if (mem_done) begin
      mem_reg.req <= 1'b0;
    end else if (end_now) begin
      // A requested cycle is never withdrawn; it completes after the end
      mem_reg.req <= mem_reg.req;
    end else if (rd_pop) begin
      mem_reg <= '{req: 1'b1, we: 1'b1, addr: mem_addr_reg, wdata: fifo_out_data};
    end else if (wr_issue) begin
      mem_reg <= '{req: 1'b1, we: 1'b0, addr: mem_addr_reg, wdata: 16'h0000};
    end
  end

  // ****************************************************************
  // Device data assembly and delivery
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !run) begin
      asm_reg <= 16'h0000;
      asm_half_reg <= 1'b0;
      asm_full_reg <= 1'b0;
      din_ready_reg <= 1'b0;
    end else begin
      if (din_take && i_prv_halfword) begin
        asm_reg <= i_prv_din.data;
      end else if (din_take && asm_half_reg) begin
        asm_reg[7:0] <= i_prv_din.data[7:0];
      end else if (din_take) begin
        asm_reg[15:8] <= i_prv_din.data[7:0];
      end
      asm_half_reg <= din_take ? (!asm_done) : asm_half_reg;
      asm_full_reg <= asm_full_next;
      din_ready_reg <= din_ready_next;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || go) begin
      prev_odd_reg <= 8'h00;
    end else if (rd_push) begin
      prev_odd_reg <= asm_data[7:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !run) begin
      dout_reg <= '0;
      out_word_reg <= 16'h0000;
      out_lo_reg <= 1'b0;
      out_last_reg <= 1'b0;
    end else if (wr_pop) begin
      dout_reg.valid <= 1'b1;
      dout_reg.data <= i_prv_halfword ? fifo_out_data : {8'h00, fifo_out_data[15:8]};
      out_word_reg <= fifo_out_data;
      // Even final address in byte mode write sends only the even byte
      out_lo_reg <= !i_prv_halfword && !dev_one_byte;
      out_last_reg <= dev_end;
    end else if (dout_take && out_lo_reg) begin
      dout_reg.data <= {8'h00, out_word_reg[7:0]};
      out_lo_reg <= 1'b0;
    end else if (dout_take) begin
      dout_reg.valid <= 1'b0;
    end
  end

  // ****************************************************************
  // Processor side registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rsp_reg <= '0;
      prv_op_reg <= '0;
      sel_reg <= 4'h0;
      tack_reg <= 1'b0;
    end else begin
      prv_op_reg <= prv_pass ? i_mpx_op : '0;
      sel_reg <= prv_pass ? i_mpx_op.dev[3:0] : sel_reg;
      tack_reg <= i_tack_in && !want_bus;
      if (to_chan) begin
        rsp_reg <= '{valid: 1'b1, false_sync: 1'b0, data: rsp_data};
      end else if (false_sync) begin
        rsp_reg <= '{valid: 1'b1, false_sync: 1'b1, data: 16'h0000};
      end else if (i_prv_rsp.valid && idle) begin
        rsp_reg <= i_prv_rsp;
      end else begin
        rsp_reg <= '0;
      end
    end
  end

  assign o_mpx_rsp = rsp_reg;
  assign o_prv_op = prv_op_reg;
  assign o_prv_sel = sel_reg;
  assign o_prv_din_ready = din_ready_reg;
  assign o_prv_dout = dout_reg;
  assign o_mem = mem_reg;
  assign o_irq = irq_reg;
  assign o_tack_out = tack_reg;

endmodule : sc_channel

// ### hw/sc_defs.svh
// Purpose: Constants of the block transfer channel.
// Assumes: Bit 0 of every vector is the least significant bit.
// Notes: Status and command bit numbers count from the MSB of the byte.
//
// Behaviour
// - Sixteen private devices, one moves data
// - Memory cycles taken by stealing, processor continues
// - Private devices outrank later daisy chain devices
// - Device moves bytes or halfwords per its mode
// - Status bit 4 set while moving data
// - Idle status is device status, bit 4 cleared
// - Command bit 2 selects read, set each time
// - Every completion returns channel to write mode
// - Command bit 3 starts, may accompany read
// - Command bit 4 halts and initializes
// - Acknowledge clears interrupt, returns number and status
// - Idle channel passes private bus through
// - Last addressed device is served after start
// - Private access while busy refused, false sync
// - Sixteen bit start counter and final limit
// - Inclusive limits, finish on address match
// - Memory access moves halfword, LSB picks byte
// - Read ending even copies previous odd byte
// - Four address bytes loaded in fixed order
// - Data reads return last memory address used
// - Address wrap to zero ends transfer abnormally
// - Device fault, end of medium, examine end it
// - Every termination except stop raises an interrupt
// - Stop forces write mode, idle, no interrupt
`ifndef SC_DEFS_SVH
`define SC_DEFS_SVH

// ****************************************************************
// Device numbers
// ****************************************************************
`define SC_DEV_NUM 8'hF0
`define SC_PRV_HI 4'hC

// ****************************************************************
// Byte fields, vector index = 7 - documented bit
// ****************************************************************
`define SC_CMD_READ 5
`define SC_CMD_GO 4
`define SC_CMD_STOP 3
`define SC_STAT_BSY 3
`define SC_STAT_EX 6
`define SC_STAT_EOM 5
`define SC_STAT_DU 2

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define SC_ADDR_RST 16'h0000
`define SC_LIM_RST 32'h0000_0000
`define SC_ADDR_TOP 16'hFFFE
`define SC_FIFO_WIDTH 16
`define SC_FIFO_DEPTH 32

`endif

// ### hw/sc_pkg.sv
// Purpose: Types of the block transfer channel.
// Assumes: Constants live in sc_defs.svh.
// Notes: No import; users write sc_pkg::name.
package sc_pkg;

  typedef enum logic [2:0] {
    SC_OP_NONE = 3'h0,
    SC_OP_CMD = 3'h1,
    SC_OP_STAT = 3'h2,
    SC_OP_WBYTE = 3'h3,
    SC_OP_WHALF = 3'h4,
    SC_OP_RBYTE = 3'h5,
    SC_OP_RHALF = 3'h6,
    SC_OP_ACK = 3'h7
  } sc_op_kind_t;

  typedef enum logic [1:0] {
    SC_ST_IDLE = 2'b01,
    SC_ST_RUN = 2'b10
  } sc_state_t;

  typedef struct packed {
    logic valid;
    sc_op_kind_t kind;
    logic [7:0] dev;
    logic [15:0] data;
  } sc_op_t;

  typedef struct packed {
    logic valid;
    logic false_sync;
    logic [15:0] data;
  } sc_rsp_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sc_word_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sc_mem_t;

endpackage : sc_pkg

// ### verification/sc_channel_assertions.sv
// Purpose: Port checks of the block transfer channel.
// Assumes: Bound to sc_channel; private attention held low.
// Notes: Busy is not a port, so refusal is seen through false sync.
`timescale 1ns/1ps
`include "sc_defs.svh"
// ****
// Checker
// ****
module sc_channel_assertions (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire sc_pkg::sc_op_t i_mpx_op,
  input wire sc_pkg::sc_rsp_t o_mpx_rsp,
  input wire logic i_tack_in,
  input wire logic o_tack_out,
  input wire logic o_irq,
  input wire sc_pkg::sc_op_t o_prv_op,
  input wire logic [3:0] o_prv_sel,
  input wire logic i_prv_attn,
  input wire sc_pkg::sc_mem_t o_mem,
  input wire logic i_mem_ack
);
  wire logic ch_op;
  wire logic pv_op;
  assign ch_op = i_mpx_op.valid && i_mpx_op.dev == `SC_DEV_NUM;
  assign pv_op = i_mpx_op.valid && i_mpx_op.dev[7:4] == `SC_PRV_HI;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  a_chan_op_answer:
  assert property (ch_op |=> o_mpx_rsp.valid && !o_mpx_rsp.false_sync)
    else $error("channel op unanswered");
  a_stop_clears_irq:
  assert property (ch_op && i_mpx_op.kind == sc_pkg::SC_OP_CMD
    && i_mpx_op.data[`SC_CMD_STOP] |=> !o_irq) else $error("stop kept irq");
  a_ack_clears_irq:
  assert property (ch_op && i_mpx_op.kind == sc_pkg::SC_OP_ACK && o_irq |=> !o_irq)
    else $error("ack kept irq");
  a_ack_gives_number:
  assert property (ch_op && i_mpx_op.kind == sc_pkg::SC_OP_ACK |=>
    o_mpx_rsp.data[15:8] == `SC_DEV_NUM && !o_mpx_rsp.data[`SC_STAT_BSY])
    else $error("ack data wrong");
  a_prv_pass_or_refuse:
  assert property (pv_op |=> (o_prv_op.valid && o_prv_sel == $past(i_mpx_op.dev[3:0]))
    || (o_mpx_rsp.valid && o_mpx_rsp.false_sync)) else $error("private op lost");
  a_mem_req_holds:
  assert property (o_mem.req && !i_mem_ack |=> o_mem.req && $stable(o_mem.addr)
    && $stable(o_mem.we)) else $error("memory request moved");
  a_mem_one_access:
  assert property (o_mem.req && i_mem_ack |=> !o_mem.req)
    else $error("request after ack");
  a_mem_halfword:
  assert property (o_mem.req |-> !o_mem.addr[0]) else $error("odd memory address");
  a_tack_chain:
  assert property (!$past(i_srst) && !$past(i_prv_attn) |->
    o_tack_out == ($past(i_tack_in) && !$past(o_irq))) else $error("chain ack wrong");
  a_irq_level:
  assert property (o_irq && !i_mpx_op.valid |=> o_irq) else $error("irq dropped");
endmodule : sc_channel_assertions

bind sc_channel sc_channel_assertions i_sc_channel_assertions (.*);

// ### verification/sc_partner.sv
// Purpose: Memory and private device facing the channel.
// Assumes: Only 512 bytes of memory are modelled; high pages alias.
// Notes: Released data lines toggle so stale values never match.
`timescale 1ns/1ps
// ****
// Partner
// ****
module sc_partner #(
  parameter logic [15:0] PRV_ANSWER = 16'h005A
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_slow,
  input wire sc_pkg::sc_mem_t i_mem,
  output logic o_mem_ack,
  output logic [15:0] o_mem_rdata,
  input wire sc_pkg::sc_op_t i_prv_op,
  output sc_pkg::sc_rsp_t o_prv_rsp,
  input wire logic i_din_ready,
  output sc_pkg::sc_word_t o_din,
  input wire sc_pkg::sc_word_t i_dout,
  output logic o_dout_ready
);
  logic [15:0] mem [0:255];
  logic [2:0] wait_cnt;
  logic [7:0] byte_cnt;
  int n_dout;
  logic [15:0] last_dout;
  assign o_din = '{1'b1, {byte_cnt, byte_cnt}};
  initial begin
    o_mem_rdata = 16'h0000;
    o_dout_ready = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hA500 ^ 16'(i);
    end
  end
  // Device stalls every other cycle when taking data; it supplies data without stalls
  always @(posedge i_sys_clk) begin
    o_mem_ack <= 1'b0;
    o_mem_rdata <= ~o_mem_rdata;
    o_prv_rsp <= '{i_prv_op.valid, 1'b0, PRV_ANSWER};
    o_dout_ready <= ~o_dout_ready && !i_srst;
    if (i_srst) begin
      wait_cnt <= 3'h0;
      byte_cnt <= 8'h40;
      n_dout <= 0;
    end else begin
      if (i_mem.req && !o_mem_ack) begin
        wait_cnt <= wait_cnt + 3'h1;
        if (wait_cnt == (i_slow ? 3'h3 : 3'h0)) begin
          wait_cnt <= 3'h0;
          o_mem_ack <= 1'b1;
          o_mem_rdata <= mem[i_mem.addr[8:1]];
          if (i_mem.we) begin
            mem[i_mem.addr[8:1]] <= i_mem.wdata;
          end
        end
      end
      if (i_din_ready) begin
        byte_cnt <= byte_cnt + 8'h01;
      end
      if (i_dout.valid && o_dout_ready) begin
        n_dout <= n_dout + 1;
        last_dout <= i_dout.data;
      end
    end
  end
endmodule : sc_partner

// ### verification/tb.sv
// Purpose: Self-checking bench of the block transfer channel.
// Assumes: Partner memory holds A500 xor halfword index.
// Notes: Attention is held low; chain ack drops once.
`timescale 1ns/1ps
`include "sc_defs.svh"
// ****
// Bench
// ****
module tb;
  localparam logic [7:0] CH = `SC_DEV_NUM;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  sc_pkg::sc_op_t i_mpx_op = '0;
  sc_pkg::sc_rsp_t o_mpx_rsp;
  logic i_tack_in = 1'b1;
  logic o_tack_out;
  logic o_irq;
  sc_pkg::sc_op_t o_prv_op;
  sc_pkg::sc_rsp_t i_prv_rsp;
  logic [7:0] i_prv_status = 8'hFF;
  logic i_prv_attn = 1'b0;
  logic i_prv_halfword = 1'b0;
  logic [3:0] o_prv_sel;
  sc_pkg::sc_word_t i_prv_din;
  logic o_prv_din_ready;
  sc_pkg::sc_word_t o_prv_dout;
  logic i_prv_dout_ready;
  sc_pkg::sc_mem_t o_mem;
  logic i_mem_ack;
  logic [15:0] i_mem_rdata;
  logic slow = 1'b0;
  sc_pkg::sc_rsp_t r;
  int fb[3] = '{`SC_STAT_EX, `SC_STAT_EOM, `SC_STAT_DU};
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  sc_channel i_sc_channel (.*);
  sc_partner i_sc_partner (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_slow(slow),
    .i_mem(o_mem), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata), .i_prv_op(o_prv_op),
    .o_prv_rsp(i_prv_rsp), .i_din_ready(o_prv_din_ready), .o_din(i_prv_din),
    .i_dout(o_prv_dout), .o_dout_ready(i_prv_dout_ready));
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input sc_pkg::sc_op_kind_t k, input logic [7:0] d, input logic [15:0] v);
    @(posedge i_sys_clk);
    i_mpx_op <= '{1'b1, k, d, v};
    @(posedge i_sys_clk);
    i_mpx_op <= '0;
    r = '0;
    for (int n = 0; n < 9 && r.valid !== 1'b1; n++) begin
      #1;
      if (o_mpx_rsp.valid === 1'b1) r = o_mpx_rsp;
      if (r.valid !== 1'b1) @(posedge i_sys_clk);
    end
    chk(16'(r.valid), 16'h0001);
  endtask : op
  task automatic run(input logic [15:0] s, input logic [15:0] f, input logic [7:0] c);
    op(sc_pkg::SC_OP_CMD, CH, 16'h0008);
    op(sc_pkg::SC_OP_WHALF, CH, s);
    op(sc_pkg::SC_OP_WHALF, CH, f);
    op(sc_pkg::SC_OP_CMD, CH, {8'h00, c});
  endtask : run
  task automatic wait_irq();
    for (int n = 0; n < 400 && o_irq !== 1'b1; n++) @(posedge i_sys_clk);
    #1;
    chk(16'(o_irq), 16'h0001);
  endtask : wait_irq
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk(16'(o_irq), 16'h0000);
    @(posedge i_sys_clk) i_tack_in <= 1'b0;
    @(posedge i_sys_clk) i_tack_in <= 1'b1;
    #1;
    chk(16'(o_tack_out), 16'h0000);
    op(sc_pkg::SC_OP_STAT, CH, 16'h0000);
    chk({8'h00, r.data[7:0]}, 16'h00F7);
    op(sc_pkg::SC_OP_CMD, 8'hC3, 16'h0012);
    chk(r.data, 16'h005A);
    chk({12'h000, o_prv_sel}, 16'h0003);
    @(posedge i_sys_clk) i_prv_status <= 8'h09;
    run(16'h0020, 16'h0022, 8'h30);
    wait_irq();
    chk(16'(o_tack_out), 16'h0000);
    chk(i_sc_partner.mem[16], 16'h4041);
    chk(i_sc_partner.mem[17], 16'h4241);
    op(sc_pkg::SC_OP_ACK, CH, 16'h0000);
    chk(r.data, {CH, 8'h01});
    chk(16'(o_irq), 16'h0000);
    @(posedge i_sys_clk) i_prv_halfword <= 1'b1;
    run(16'h0010, 16'h0015, 8'h10);
    wait_irq();
    chk(16'(i_sc_partner.n_dout), 16'h0003);
    chk(i_sc_partner.last_dout, 16'hA50A);
    chk(i_sc_partner.mem[8], 16'hA508);
    op(sc_pkg::SC_OP_RHALF, CH, 16'h0000);
    chk(r.data, 16'h0014);
    run(16'hFFFC, 16'h0002, 8'h10);
    wait_irq();
    chk(16'(i_sc_partner.n_dout), 16'h0005);
    op(sc_pkg::SC_OP_RHALF, CH, 16'h0000);
    chk(r.data, 16'hFFFE);
    @(posedge i_sys_clk) slow <= 1'b1;
    foreach (fb[i]) begin
      run(16'h0030, 16'h007E, 8'h10);
      op(sc_pkg::SC_OP_STAT, CH, 16'h0000);
      chk({8'h00, r.data[7:0]}, 16'h0008);
      op(sc_pkg::SC_OP_CMD, 8'hC5, 16'h0000);
      chk(16'(r.false_sync), 16'h0001);
      @(posedge i_sys_clk) i_prv_status[fb[i]] <= 1'b1;
      wait_irq();
      op(sc_pkg::SC_OP_RHALF, CH, 16'h0000);
      chk(16'(r.data < 16'h0070), 16'h0001);
      @(posedge i_sys_clk) i_prv_status <= 8'h09;
    end
    run(16'h0040, 16'h00FE, 8'h30);
    repeat (12) @(posedge i_sys_clk);
    op(sc_pkg::SC_OP_CMD, CH, 16'h0008);
    repeat (8) @(posedge i_sys_clk);
    #1;
    chk({15'h0000, o_irq}, 16'h0000);
    chk({15'h0000, o_mem.req}, 16'h0000);
    run(16'h0060, 16'h0062, 8'h10);
    wait_irq();
    chk(i_sc_partner.mem[48], 16'hA530);
    give_verdict();
  end
endmodule : tb
